// *** design/audio_control_regs.sv ***
// holds the control/status registers and the control decode they drive
// assumes register strobes come from the serial control port already decoded
// into byte address and data on sys_clk_in; receiver signals are synchronous
`timescale 1ns/1ps
`default_nettype none
module audio_control_regs #(
	parameter int RAMP_STEP = audio_regs_pkg::RAMP_STEP_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic [2:0] main_port_selector_in,
	input wire logic [1:0] zero_cross_in,
	input wire logic rx_locked_in,
	input wire logic rx_parity_error_in,
	input wire logic rx_status_load_in,
	input wire logic [47:0] rx_status_bits_in,
	input wire logic [2:0] rx_sysclk_rate_in,
	input wire logic tx_bit_clk_in,
	input wire logic [23:0] tx_audio_in,
	output logic [7:0] left_gain_code_out,
	output logic [7:0] right_gain_code_out,
	output logic [1:0] gain_muted_out,
	output logic [7:0] left_ramp_level_out,
	output logic [7:0] right_ramp_level_out,
	output logic [2:0] conv_iface_mode_out,
	output logic conv_clock_driver_out,
	output logic [1:0] conv_out_format_out,
	output logic highpass_bypass_out,
	output logic input_polarity_out,
	output logic [2:0] tx_sysclk_source_out,
	output logic [2:0] tx_frame_source_out,
	output logic [2:0] tx_sysclk_rate_out,
	output logic tx_onebit_input_en_out,
	output logic [1:0] tx_in_format_out,
	output logic tx_frame_clk_out,
	output logic [23:0] tx_audio_out
);
	logic [7:0] att_reg [2];
	logic [7:0] iface_fmt_reg;
	logic [7:0] filt_mute_reg;
	logic [7:0] tx_source_reg;
	logic [7:0] tx_clk_fmt_reg;
	logic [47:0] rx_status_reg;
	logic [7:0] applied_gain_reg [2];
	logic [7:0] ramp_level_reg [2];
	logic [7:0] rdata_next;
	logic [2:0] bclk_sync_reg;
	logic bclk_level_reg;
	logic [5:0] frame_count_reg;
	logic frame_clk_reg;
	logic [23:0] tx_audio_reg;
	logic zero_cross_off;
	logic [2:0] iface_mode;
	logic onebit_en;
	logic bclk_rise;

	assign zero_cross_off = filt_mute_reg[audio_regs_pkg::ZERO_CROSS_BIT];
	assign iface_mode = iface_fmt_reg[audio_regs_pkg::IFACE_MODE_LSB +: 3];
	assign onebit_en = tx_clk_fmt_reg[audio_regs_pkg::TX_ONEBIT_BIT];

	// register writes; reserved bits are masked so they always read zero
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			att_reg[0] <= audio_regs_pkg::RESET_ATT;
			att_reg[1] <= audio_regs_pkg::RESET_ATT;
			iface_fmt_reg <= audio_regs_pkg::RESET_IFACE_FMT;
			filt_mute_reg <= audio_regs_pkg::RESET_FILT_MUTE;
			tx_source_reg <= audio_regs_pkg::RESET_TX_SOURCE;
			tx_clk_fmt_reg <= audio_regs_pkg::RESET_TX_CLK_FMT;
		end else if (reg_write_in) begin
			unique case (reg_addr_in)
				audio_regs_pkg::ADDR_LEFT_ATT: att_reg[0] <= reg_wdata_in;
				audio_regs_pkg::ADDR_RIGHT_ATT: att_reg[1] <= reg_wdata_in;
				audio_regs_pkg::ADDR_IFACE_FMT: begin
					iface_fmt_reg <= reg_wdata_in & audio_regs_pkg::MASK_IFACE_FMT;
				end
				audio_regs_pkg::ADDR_FILT_MUTE: begin
					filt_mute_reg <= reg_wdata_in & audio_regs_pkg::MASK_FILT_MUTE;
				end
				audio_regs_pkg::ADDR_TX_SOURCE: begin
					tx_source_reg <= reg_wdata_in & audio_regs_pkg::MASK_TX_SOURCE;
				end
				audio_regs_pkg::ADDR_TX_CLK_FMT: begin
					tx_clk_fmt_reg <= reg_wdata_in & audio_regs_pkg::MASK_TX_CLK_FMT;
				end
				default: begin
				end
			endcase
		end
	end

	// status buffer: clear beats load so a stale block never survives a dropout
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_status_reg <= audio_regs_pkg::RESET_RX_STATUS;
		end else if (!rx_locked_in || rx_parity_error_in) begin
			rx_status_reg <= audio_regs_pkg::RESET_RX_STATUS;
		end else if (rx_status_load_in) begin
			for (int i = 0; i < 48; i++) begin
				rx_status_reg[47 - i] <= rx_status_bits_in[i];
			end
		end
	end

	// read data; buffer bytes run from status bits 0..7 at the first address
	always_comb begin
		rdata_next = 8'h00;
		if (reg_addr_in >= audio_regs_pkg::ADDR_RX_STATUS_FIRST &&
				reg_addr_in <= audio_regs_pkg::ADDR_RX_STATUS_LAST) begin
			rdata_next = rx_status_reg[8'(8'd47 - 8'(8'd8 * (reg_addr_in -
				audio_regs_pkg::ADDR_RX_STATUS_FIRST))) -: 8];
		end else begin
			unique case (reg_addr_in)
				audio_regs_pkg::ADDR_LEFT_ATT: rdata_next = att_reg[0];
				audio_regs_pkg::ADDR_RIGHT_ATT: rdata_next = att_reg[1];
				audio_regs_pkg::ADDR_IFACE_FMT: rdata_next = iface_fmt_reg;
				audio_regs_pkg::ADDR_FILT_MUTE: rdata_next = filt_mute_reg;
				audio_regs_pkg::ADDR_TX_SOURCE: rdata_next = tx_source_reg;
				audio_regs_pkg::ADDR_TX_CLK_FMT: rdata_next = tx_clk_fmt_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_read_in;
			if (reg_read_in) begin
				reg_rdata_out <= rdata_next;
			end
		end
	end

	// per-channel gain apply and soft-mute ramp
	for (genvar ch = 0; ch < 2; ch++) begin : chan_gen
		logic [$clog2(RAMP_STEP + 1) - 1:0] step_count_reg;
		logic mute_on;
		assign mute_on = filt_mute_reg[ch == 0 ? audio_regs_pkg::LEFT_MUTE_BIT :
			audio_regs_pkg::RIGHT_MUTE_BIT];

		// changes land on a zero crossing so no click is heard, or at once when the zero-cross bit is set
		always_ff @(posedge sys_clk_in or posedge rst_in) begin
			if (rst_in) begin
				applied_gain_reg[ch] <= audio_regs_pkg::RESET_ATT;
			end else if (zero_cross_off || zero_cross_in[ch]) begin
				applied_gain_reg[ch] <= att_reg[ch];
			end
		end

		always_ff @(posedge sys_clk_in or posedge rst_in) begin
			if (rst_in) begin
				step_count_reg <= '0;
				ramp_level_reg[ch] <= audio_regs_pkg::RAMP_FULL;
			end else if (step_count_reg == ($bits(step_count_reg))'(RAMP_STEP - 1)) begin
				step_count_reg <= '0;
				if (mute_on && ramp_level_reg[ch] != 8'h00) begin
					ramp_level_reg[ch] <= ramp_level_reg[ch] - 8'h01;
				end else if (!mute_on && ramp_level_reg[ch] != audio_regs_pkg::RAMP_FULL) begin
					ramp_level_reg[ch] <= ramp_level_reg[ch] + 8'h01;
				end
			end else begin
				step_count_reg <= step_count_reg + 1'b1;
			end
		end

		// codes under the floor mean full mute
		assign gain_muted_out[ch] = applied_gain_reg[ch] < audio_regs_pkg::GAIN_MUTE_BELOW;
	end

	assign left_gain_code_out = applied_gain_reg[0];
	assign right_gain_code_out = applied_gain_reg[1];
	assign left_ramp_level_out = ramp_level_reg[0];
	assign right_ramp_level_out = ramp_level_reg[1];

	// reserved mode codes fall back to peripheral operation
	always_comb begin
		conv_iface_mode_out = audio_regs_pkg::IFACE_PERIPHERAL;
		if (main_port_selector_in == audio_regs_pkg::SELECTOR_CONV_ALONE &&
				(iface_mode == audio_regs_pkg::IFACE_DRIVE_512 ||
				iface_mode == audio_regs_pkg::IFACE_DRIVE_256)) begin
			conv_iface_mode_out = iface_mode;
		end
	end
	assign conv_clock_driver_out = conv_iface_mode_out != audio_regs_pkg::IFACE_PERIPHERAL;
	assign conv_out_format_out = iface_fmt_reg[audio_regs_pkg::CONV_FMT_LSB +: 2];
	assign highpass_bypass_out = filt_mute_reg[audio_regs_pkg::BYPASS_BIT];
	assign input_polarity_out = filt_mute_reg[audio_regs_pkg::POLARITY_BIT];

	// resolve the automatic source against receiver lock
	function automatic logic [2:0] resolve_source(input logic [2:0] code, input logic locked);
		logic [2:0] result;
		result = code;
		if (code == audio_regs_pkg::SRC_AUTO) begin
			result = locked ? audio_regs_pkg::SRC_RECEIVER : audio_regs_pkg::SRC_CONVERTER;
		end
		return result;
	endfunction

	assign tx_sysclk_source_out = resolve_source(tx_source_reg[audio_regs_pkg::TX_SYSCLK_SRC_LSB +: 3],
		rx_locked_in);
	assign tx_frame_source_out = resolve_source(tx_source_reg[audio_regs_pkg::TX_FRAME_SRC_LSB +: 3],
		rx_locked_in);

	always_comb begin
		tx_sysclk_rate_out = tx_clk_fmt_reg[audio_regs_pkg::TX_SYSCLK_RATE_LSB +: 3];
		if (tx_sysclk_rate_out[2]) begin
			tx_sysclk_rate_out = rx_sysclk_rate_in;
		end
	end
	assign tx_onebit_input_en_out = onebit_en;
	assign tx_in_format_out = tx_clk_fmt_reg[audio_regs_pkg::TX_FMT_LSB +: 2];

	// bit clock arrives from a pin: three stages, change counted when last two agree
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bclk_sync_reg <= 3'h0;
			bclk_level_reg <= 1'b0;
		end else begin
			bclk_sync_reg <= {bclk_sync_reg[1:0], tx_bit_clk_in};
			if (bclk_sync_reg[1] == bclk_sync_reg[2]) begin
				bclk_level_reg <= bclk_sync_reg[2];
			end
		end
	end
	assign bclk_rise = bclk_sync_reg[1] && bclk_sync_reg[2] && !bclk_level_reg;

	// frame clock toggles every half of the divide, only in one-bit input mode
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			frame_count_reg <= 6'h00;
			frame_clk_reg <= 1'b0;
		end else if (!onebit_en) begin
			frame_count_reg <= 6'h00;
			frame_clk_reg <= 1'b0;
		end else if (bclk_rise) begin
			frame_count_reg <= frame_count_reg + 6'h01;
			if (frame_count_reg == 6'(audio_regs_pkg::FRAME_DIVIDE / 2 - 1) ||
					frame_count_reg == 6'(audio_regs_pkg::FRAME_DIVIDE - 1)) begin
				frame_clk_reg <= !frame_clk_reg;
			end
		end
	end
	assign tx_frame_clk_out = frame_clk_reg;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_audio_reg <= 24'h000000;
		end else begin
			tx_audio_reg <= onebit_en ? 24'h000000 : tx_audio_in;
		end
	end
	assign tx_audio_out = tx_audio_reg;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	status_clear_a: assert property ((!rx_locked_in || rx_parity_error_in) |=>
		rx_status_reg == 48'h000000000000)
		else $error("status buffer not cleared on unlock or parity error");
	status_order_a: assert property ((rx_locked_in && !rx_parity_error_in && rx_status_load_in) |=>
		rx_status_reg[47] == $past(rx_status_bits_in[0]) &&
		rx_status_reg[0] == $past(rx_status_bits_in[47]))
		else $error("status bits stored in wrong order");
	drive_gate_a: assert property ((main_port_selector_in != 3'h1) |->
		conv_iface_mode_out == 3'h0)
		else $error("clock driving outside standalone mode");
	drive_mode_a: assert property ((main_port_selector_in == 3'h1 && iface_mode == 3'h2) |->
		conv_clock_driver_out)
		else $error("512x clock driving mode not honoured");
	gain_hold_a: assert property ((!zero_cross_off && !zero_cross_in[0]) |=>
		$stable(applied_gain_reg[0]))
		else $error("left gain changed without zero crossing");
	gain_mute_a: assert property ((applied_gain_reg[1] == 8'h0E) |-> gain_muted_out[1])
		else $error("right gain code below floor not muted");
	gain_floor_a: assert property ((applied_gain_reg[0] == 8'h0F) |-> !gain_muted_out[0])
		else $error("left gain at floor wrongly muted");
	auto_source_a: assert property ((tx_source_reg[6:4] == 3'h0 && !rx_locked_in) |->
		tx_sysclk_source_out == 3'h2)
		else $error("automatic source not converter while unlocked");
	frame_source_a: assert property ((tx_source_reg[2:0] == 3'h0 && rx_locked_in) |->
		tx_frame_source_out == 3'h1)
		else $error("automatic frame source not receiver while locked");
	rate_follow_a: assert property (tx_clk_fmt_reg[6] |-> tx_sysclk_rate_out == rx_sysclk_rate_in)
		else $error("upper rate codes do not follow receiver");
	onebit_zero_a: assert property (onebit_en |=> tx_audio_out == 24'h000000)
		else $error("one-bit mode audio not forced to zero");
	ramp_down_a: assert property ((filt_mute_reg[0] && ramp_level_reg[0] != 8'h00 &&
		chan_gen[0].step_count_reg == ($bits(chan_gen[0].step_count_reg))'(RAMP_STEP - 1)) |=>
		ramp_level_reg[0] == $past(ramp_level_reg[0]) - 8'h01)
		else $error("soft mute ramp did not step down");
endmodule
`default_nettype wire

// *** design/audio_regs_pkg.sv ***
// constants for the audio transceiver control and status registers
// assumes byte-wide register access through the serial control port
package audio_regs_pkg;
	localparam logic [7:0] ADDR_LEFT_ATT = 8'h46;
	localparam logic [7:0] ADDR_RIGHT_ATT = 8'h47;
	localparam logic [7:0] ADDR_IFACE_FMT = 8'h48;
	localparam logic [7:0] ADDR_FILT_MUTE = 8'h49;
	localparam logic [7:0] ADDR_RX_STATUS_FIRST = 8'h5A;
	localparam logic [7:0] ADDR_RX_STATUS_LAST = 8'h5F;
	localparam logic [7:0] ADDR_TX_SOURCE = 8'h60;
	localparam logic [7:0] ADDR_TX_CLK_FMT = 8'h61;

	localparam logic [7:0] RESET_ATT = 8'hD7;
	localparam logic [7:0] RESET_IFACE_FMT = 8'h00;
	localparam logic [7:0] RESET_FILT_MUTE = 8'h00;
	localparam logic [7:0] RESET_TX_SOURCE = 8'h44;
	localparam logic [7:0] RESET_TX_CLK_FMT = 8'h10;
	localparam logic [47:0] RESET_RX_STATUS = 48'h000000000000;

	// writable bits of each register; reserved bits read as zero
	localparam logic [7:0] MASK_IFACE_FMT = 8'h73;
	localparam logic [7:0] MASK_FILT_MUTE = 8'h1F;
	localparam logic [7:0] MASK_TX_SOURCE = 8'h77;
	localparam logic [7:0] MASK_TX_CLK_FMT = 8'h77;

	localparam int IFACE_MODE_LSB = 4;
	localparam int CONV_FMT_LSB = 0;
	localparam int ZERO_CROSS_BIT = 4;
	localparam int BYPASS_BIT = 3;
	localparam int POLARITY_BIT = 2;
	localparam int RIGHT_MUTE_BIT = 1;
	localparam int LEFT_MUTE_BIT = 0;
	localparam int TX_SYSCLK_SRC_LSB = 4;
	localparam int TX_FRAME_SRC_LSB = 0;
	localparam int TX_SYSCLK_RATE_LSB = 4;
	localparam int TX_ONEBIT_BIT = 2;
	localparam int TX_FMT_LSB = 0;

	localparam logic [7:0] GAIN_MUTE_BELOW = 8'h0F;
	localparam logic [2:0] IFACE_PERIPHERAL = 3'h0;
	localparam logic [2:0] IFACE_DRIVE_512 = 3'h2;
	localparam logic [2:0] IFACE_DRIVE_256 = 3'h4;
	localparam logic [2:0] SELECTOR_CONV_ALONE = 3'h1;

	localparam logic [2:0] SRC_AUTO = 3'h0;
	localparam logic [2:0] SRC_RECEIVER = 3'h1;
	localparam logic [2:0] SRC_CONVERTER = 3'h2;
	localparam logic [2:0] SRC_AUX_LAST = 3'h5;
	localparam logic [2:0] RATE_128 = 3'h0;
	localparam logic [2:0] RATE_512 = 3'h2;
	localparam logic [2:0] RATE_RESERVED = 3'h3;

	localparam int FRAME_DIVIDE = 64;
	localparam int RAMP_STEP_NS = 160;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] RAMP_FULL = 8'hFF;
endpackage

// *** tb/audio_adc_dir_dit_control_regs_bench.sv ***
// self-checking bench for the audio control and status register block
// assumes the block alone on sys_clk_in, every input driven here at the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module audio_adc_dir_dit_control_regs_bench;
	localparam int STEP = 2;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic reg_write_in = 1'b0, reg_read_in = 1'b0, reg_rvalid_out;
	logic [2:0] main_port_selector_in = 3'h0, rx_sysclk_rate_in = 3'h0;
	logic [1:0] zero_cross_in = 2'h0, gain_muted_out, conv_out_format_out, tx_in_format_out;
	logic rx_locked_in = 1'b1, rx_parity_error_in = 1'b0, rx_status_load_in = 1'b0;
	logic [47:0] rx_status_bits_in = 48'h123456789ABC;
	logic tx_bit_clk_in = 1'b0, conv_clock_driver_out, highpass_bypass_out, input_polarity_out;
	logic [23:0] tx_audio_in = 24'hABCDEF, tx_audio_out;
	logic [7:0] left_gain_code_out, right_gain_code_out, left_ramp_level_out, right_ramp_level_out;
	logic [2:0] conv_iface_mode_out, tx_sysclk_source_out, tx_frame_source_out, tx_sysclk_rate_out;
	logic tx_onebit_input_en_out, tx_frame_clk_out;
	int miscompares = 0;
	int n_checks = 0;

	audio_control_regs #(.RAMP_STEP(STEP)) uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
		.main_port_selector_in(main_port_selector_in), .zero_cross_in(zero_cross_in),
		.rx_locked_in(rx_locked_in), .rx_parity_error_in(rx_parity_error_in),
		.rx_status_load_in(rx_status_load_in), .rx_status_bits_in(rx_status_bits_in),
		.rx_sysclk_rate_in(rx_sysclk_rate_in), .tx_bit_clk_in(tx_bit_clk_in),
		.tx_audio_in(tx_audio_in), .left_gain_code_out(left_gain_code_out),
		.right_gain_code_out(right_gain_code_out), .gain_muted_out(gain_muted_out),
		.left_ramp_level_out(left_ramp_level_out), .right_ramp_level_out(right_ramp_level_out),
		.conv_iface_mode_out(conv_iface_mode_out), .conv_clock_driver_out(conv_clock_driver_out),
		.conv_out_format_out(conv_out_format_out), .highpass_bypass_out(highpass_bypass_out),
		.input_polarity_out(input_polarity_out), .tx_sysclk_source_out(tx_sysclk_source_out),
		.tx_frame_source_out(tx_frame_source_out), .tx_sysclk_rate_out(tx_sysclk_rate_out),
		.tx_onebit_input_en_out(tx_onebit_input_en_out), .tx_in_format_out(tx_in_format_out),
		.tx_frame_clk_out(tx_frame_clk_out), .tx_audio_out(tx_audio_out));

	always #5 sys_clk_in = ~sys_clk_in;

	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_write_in = 1'b1;
		cyc(1);
		reg_write_in = 1'b0;
	endtask

	// the answer pulse is awaited for a few cycles only
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
		int i;
		cyc(1);
		reg_addr_in = a;
		reg_read_in = 1'b1;
		cyc(1);
		reg_read_in = 1'b0;
		for (i = 0; i < 3 && reg_rvalid_out !== 1'b1; i++)
			cyc(1);
		`CHK("read_valid", 1'b1, reg_rvalid_out)
		if (reg_rvalid_out !== 1'b1)
			finish_test();
		`CHK("read_data", ex, reg_rdata_out)
	endtask

	task automatic pulse_zc(input logic [1:0] v);
		cyc(1);
		zero_cross_in = v;
		cyc(1);
		zero_cross_in = 2'h0;
	endtask

	task automatic t_reset();
		rd_chk(8'h46, 8'hD7);
		rd_chk(8'h47, 8'hD7);
		rd_chk(8'h48, 8'h00);
		rd_chk(8'h49, 8'h00);
		rd_chk(8'h5A, 8'h00);
		rd_chk(8'h60, 8'h44);
		rd_chk(8'h61, 8'h10);
		`CHK("ramp_left", 8'hFF, left_ramp_level_out)
		`CHK("frame_clk", 1'b0, tx_frame_clk_out)
	endtask

	task automatic t_access();
		wr(8'h48, 8'hFF);
		rd_chk(8'h48, 8'h73);
		wr(8'h49, 8'hFC);
		rd_chk(8'h49, 8'h1C);
		wr(8'h60, 8'hFF);
		rd_chk(8'h60, 8'h77);
		wr(8'h5A, 8'hFF);
		rd_chk(8'h5A, 8'h00);
		rd_chk(8'h70, 8'h00);
		wr(8'h49, 8'h00);
	endtask

	// every interface mode meets both selector settings; reserved code 3'h1 stays peripheral
	task automatic t_iface();
		logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
		logic drv;
		for (int s = 0; s < 2; s++) begin
			main_port_selector_in = 3'(s);
			for (int k = 0; k < 4; k++) begin
				wr(8'h48, {1'b0, modes[k], 2'b00, 2'(k)});
				cyc(1);
				drv = (s == 1) && (modes[k] == 3'h2 || modes[k] == 3'h4);
				`CHK("clock_driver", drv, conv_clock_driver_out)
				`CHK("iface_mode", drv ? modes[k] : 3'h0, conv_iface_mode_out)
				`CHK("out_format", 2'(k), conv_out_format_out)
			end
		end
		for (int v = 0; v < 4; v++) begin
			wr(8'h49, 8'(v << 2));
			cyc(1);
			`CHK("hp_bypass", v[1], highpass_bypass_out)
			`CHK("polarity", v[0], input_polarity_out)
		end
	endtask

	task automatic t_gain();
		wr(8'h46, 8'h20);
		wr(8'h47, 8'h0E);
		cyc(3);
		`CHK("left_held", 8'hD7, left_gain_code_out)
		pulse_zc(2'b10);
		`CHK("left_held", 8'hD7, left_gain_code_out)
		`CHK("right_gain", 8'h0E, right_gain_code_out)
		`CHK("muted", 2'b10, gain_muted_out)
		pulse_zc(2'b01);
		`CHK("left_gain", 8'h20, left_gain_code_out)
		wr(8'h49, 8'h10);
		wr(8'h46, 8'h0F);
		cyc(2);
		`CHK("left_gain", 8'h0F, left_gain_code_out)
		`CHK("muted", 2'b10, gain_muted_out)
		wr(8'h46, 8'h0E);
		cyc(2);
		`CHK("muted", 2'b11, gain_muted_out)
		wr(8'h49, 8'h00);
	endtask

	task automatic t_status();
		logic [7:0] b;
		// the bench stands in for software: the buffer is read after a valid load, then after a parity error and an unlocked load
		cyc(1);
		rx_status_load_in = 1'b1;
		cyc(1);
		rx_status_load_in = 1'b0;
		for (int k = 0; k < 6; k++) begin
			for (int j = 0; j < 8; j++)
				b[7 - j] = rx_status_bits_in[8 * k + j];
			rd_chk(8'h5A + 8'(k), b);
		end
		rx_parity_error_in = 1'b1;
		cyc(1);
		rx_parity_error_in = 1'b0;
		rd_chk(8'h5A, 8'h00);
		rx_status_load_in = 1'b1;
		cyc(1);
		rx_status_load_in = 1'b0;
		rx_locked_in = 1'b0;
		cyc(2);
		rx_status_load_in = 1'b1;
		cyc(1);
		rx_status_load_in = 1'b0;
		rd_chk(8'h5F, 8'h00);
		rx_locked_in = 1'b1;
	endtask

	task automatic t_tx();
		wr(8'h60, 8'h00);
		cyc(1);
		`CHK("sys_src", 3'h1, tx_sysclk_source_out)
		`CHK("frame_src", 3'h1, tx_frame_source_out)
		rx_locked_in = 1'b0;
		cyc(2);
		`CHK("sys_src", 3'h2, tx_sysclk_source_out)
		`CHK("frame_src", 3'h2, tx_frame_source_out)
		rx_locked_in = 1'b1;
		wr(8'h60, 8'h53);
		cyc(1);
		`CHK("sys_src", 3'h5, tx_sysclk_source_out)
		`CHK("frame_src", 3'h3, tx_frame_source_out)
		rx_sysclk_rate_in = 3'h2;
		wr(8'h61, 8'h70);
		cyc(1);
		`CHK("rate", 3'h2, tx_sysclk_rate_out)
		wr(8'h61, 8'h03);
		cyc(1);
		`CHK("rate", 3'h0, tx_sysclk_rate_out)
		`CHK("tx_format", 2'h3, tx_in_format_out)
	endtask

	// bit clock runs eight system cycles a period, well clear of the pin synchroniser
	task automatic t_onebit();
		logic prev;
		int last = -1;
		int toggles = 0;
		wr(8'h61, 8'h10);
		cyc(2);
		`CHK("audio", 24'hABCDEF, tx_audio_out)
		wr(8'h61, 8'h14);
		cyc(2);
		`CHK("onebit", 1'b1, tx_onebit_input_en_out)
		`CHK("audio", 24'h000000, tx_audio_out)
		prev = tx_frame_clk_out;
		for (int i = 0; i < 200; i++) begin
			tx_bit_clk_in = 1'b1;
			cyc(4);
			tx_bit_clk_in = 1'b0;
			cyc(4);
			if (tx_frame_clk_out !== prev) begin
				if (last >= 0)
					`CHK("half_frame", 32, i - last)
				last = i;
				prev = tx_frame_clk_out;
				toggles++;
			end
		end
		`CHK("frame_toggles", 1'b1, toggles >= 3)
		wr(8'h61, 8'h10);
	endtask

	task automatic t_ramp();
		int n = 0;
		wr(8'h49, 8'h01);
		while (n < 1000 && left_ramp_level_out !== 8'h00) begin
			cyc(1);
			n++;
		end
		`CHK("ramp_left", 8'h00, left_ramp_level_out)
		`CHK("ramp_gradual", 1'b1, n >= 254 * STEP)
		`CHK("ramp_right", 8'hFF, right_ramp_level_out)
		wr(8'h49, 8'h00);
		cyc(600);
		`CHK("ramp_left", 8'hFF, left_ramp_level_out)
	endtask

	// bound well under the cycle budget; a clean run needs only a few thousand cycles
	initial begin
		#500us;
		miscompares++;
		$display("Error watchdog expected done seen hang");
		finish_test();
	end

	initial begin
		cyc(16);
		rst_in = 1'b0;
		t_reset();
		t_access();
		t_iface();
		t_gain();
		t_status();
		t_tx();
		t_onebit();
		t_ramp();
		finish_test();
	end
endmodule
`default_nettype wire
